// file: test/slh_host_model.sv
// Host controller model that runs serial frames towards the block
`timescale 1ns/1ps
module slh_host_model (
  // Clock
  input wire logic mclk,
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so_q,
  input wire logic so_oe_n_q
);
  // High when the data line was enabled at every sample of the last frame
  logic oe_low;

  // Idle link: clock parked low, no select, data line released
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    oe_low = 1'b0;
  end

  // ****************************************
  // One whole frame, MSB first, half period in mclk cycles
  // ****************************************
  // Changes land on falling mclk edges so the block never samples mid-change
  task automatic xfer(input logic [15:0] tx, input int half, output logic [15:0] rx);
    rx = 16'h0000;
    oe_low = 1'b1;
    cs_n = 1'b0;
    repeat (half) @(negedge mclk);
    for (int i = 15; i >= 0; i--) begin
      si = tx[i];
      repeat (half) @(negedge mclk);
      sclk = 1'b1;
      rx[i] = so_q; // Settled since the previous falling clock
      oe_low = oe_low & (so_oe_n_q === 1'b0);
      repeat (half) @(negedge mclk);
      sclk = 1'b0;
    end
    repeat (half) @(negedge mclk);
    cs_n = 1'b1;
    si = ~si; // Released line has no pull, so it must not look held
    repeat (8) @(negedge mclk);
  endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the supply, reset and limp-home control block
`timescale 1ns/1ps
module testbench;
  import slh_pkg::*;
  localparam int WAKE = 20;
  // Clock, reset and pin stimulus
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic vdd_ok = 1'b0;
  logic vbb_ok = 1'b0;
  logic limp_home_enable = 1'b0;
  logic wd_overrun = 1'b0;
  logic [4:0] in_pin = 5'h00;
  logic [4:0] thermal_latch = 5'h00;
  logic sclk;
  logic cs_n;
  logic si;
  // Observed outputs
  logic so_q;
  logic so_oe_n_q;
  logic [4:0] ch_on_q;
  logic wd_active_q;
  logic limp_home_active_flag_q;
  logic standby_q;
  logic idle_q;
  logic sense_avail_q;
  logic spi_ready_q;
  logic [15:0] rsp;
  int error_cnt = 0;
  int compares = 0;

  // ****************************************
  // Clock and instances
  // ****************************************
  always #5 mclk = ~mclk;

  slh_supply_reset_ctrl #(.CH_N(5), .POR_WAKE_CYC(WAKE)) u_slh_supply_reset_ctrl (
    .mclk(mclk), .nrst(nrst), .vdd_ok(vdd_ok), .vbb_ok(vbb_ok),
    .limp_home_enable(limp_home_enable), .wd_overrun(wd_overrun), .in_pin(in_pin),
    .thermal_latch(thermal_latch), .sclk(sclk), .cs_n(cs_n), .si(si), .so_q(so_q),
    .so_oe_n_q(so_oe_n_q), .ch_on_q(ch_on_q), .wd_active_q(wd_active_q),
    .limp_home_active_flag_q(limp_home_active_flag_q), .standby_q(standby_q),
    .idle_q(idle_q), .sense_avail_q(sense_avail_q), .spi_ready_q(spi_ready_q)
  );

  slh_host_model u_slh_host_model (
    .mclk(mclk), .sclk(sclk), .cs_n(cs_n), .si(si), .so_q(so_q), .so_oe_n_q(so_oe_n_q)
  );

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask

  task automatic complete_run;
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Frame with write flag, address and data; slow frames use a longer half period
  task automatic frame(input logic wr, input logic [2:0] a, input logic [4:0] d, input int half = 4);
    u_slh_host_model.xfer({wr, a, 7'h00, d}, half, rsp);
  endtask

  // Response to a read comes on the frame after the address is sent
  task automatic rd(input logic [2:0] a);
    frame(1'b0, a, 5'h00);
    frame(1'b0, a, 5'h00);
  endtask

  task automatic settle;
    repeat (6) @(negedge mclk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Supply ramp: ready only after threshold and wake count, first answer flagged
  task automatic power_up;
    int n;
    repeat (30) @(negedge mclk);
    chk("ready before supply", 16'h0, {15'h0, spi_ready_q});
    vdd_ok = 1'b1;
    n = 0;
    while (spi_ready_q !== 1'b1 && n < WAKE + 20) begin
      @(negedge mclk);
      n++;
    end
    if (n >= WAKE + 20) begin
      error_cnt++;
      complete_run;
    end
    chk("wake too short", 16'h1, {15'h0, n >= WAKE});
    frame(1'b0, SLH_ADDR_OUT, 5'h00, 9);
    chk("first frame", 16'h8000, rsp);
    frame(1'b0, SLH_ADDR_OUT, 5'h00);
    chk("second frame", 16'h0000, rsp);
    chk("so driven in frame", 16'h1, {15'h0, u_slh_host_model.oe_low});
    chk("so released", 16'h1, {15'h0, so_oe_n_q});
    chk("idle after power-up", 16'h1, {15'h0, idle_q});
  endtask

  // Write without load supply, then reset command clears the bank only
  task automatic write_and_reset;
    frame(1'b1, SLH_ADDR_OUT, 5'h15);
    rd(SLH_ADDR_OUT);
    chk("out without vbb", 16'h0015, rsp);
    chk("channels on", 16'h15, {11'h0, ch_on_q});
    chk("idle with channels on", 16'h0, {15'h0, idle_q});
    vbb_ok = 1'b1;
    limp_home_enable = 1'b1;
    settle;
    frame(1'b1, SLH_ADDR_HARDWARE_CONFIG_REG, 5'h10);
    frame(1'b0, SLH_ADDR_OUT, 5'h00);
    chk("frame after reset command", 16'h8000, rsp);
    chk("channels after reset", 16'h0, {11'h0, ch_on_q});
    chk("watchdog kept", 16'h1, {15'h0, wd_active_q});
  endtask

  // Watchdog overrun enters limp-home; writes held off, reads still work
  task automatic limp_home;
    vbb_ok = 1'b0;
    settle;
    chk("watchdog without vbb", 16'h0, {15'h0, wd_active_q});
    vbb_ok = 1'b1;
    settle;
    wd_overrun = 1'b1;
    settle;
    wd_overrun = 1'b0;
    settle;
    chk("limp flag", 16'h1, {15'h0, limp_home_active_flag_q});
    chk("sense in limp", 16'h0, {15'h0, sense_avail_q});
    frame(1'b1, SLH_ADDR_OUT, 5'h07);
    frame(1'b1, SLH_ADDR_HARDWARE_CONFIG_REG, 5'h10);
    chk("limp kept over reset command", 16'h1, {15'h0, limp_home_active_flag_q});
    rd(SLH_ADDR_OUT);
    chk("out held in reset", 16'h0, {8'h0, rsp[7:0]});
    rd(SLH_ADDR_HARDWARE_CONFIG_REG);
    chk("hardware_config_reg limp bit", 16'h1, {15'h0, rsp[SLH_HARDWARE_CONFIG_REG_LHO_BIT]});
    rd(SLH_ADDR_STAT);
    chk("status enable and limp", 16'h3, {14'h0, rsp[1:0]});
    limp_home_enable = 1'b0;
    settle;
    chk("watchdog off", 16'h0, {15'h0, wd_active_q});
    chk("limp cleared", 16'h0, {15'h0, limp_home_active_flag_q});
    chk("sense back", 16'h1, {15'h0, sense_avail_q});
  endtask

  // Stand-by needs enable low, channels off and thermal latches clear
  task automatic standby_check;
    settle;
    chk("standby met", 16'h1, {15'h0, standby_q});
    in_pin = 5'h02;
    settle;
    chk("standby channel on", 16'h0, {15'h0, standby_q});
    chk("idle channel on", 16'h0, {15'h0, idle_q});
    in_pin = 5'h00;
    thermal_latch = 5'h04;
    settle;
    chk("standby thermal", 16'h0, {15'h0, standby_q});
    limp_home_enable = 1'b1;
    thermal_latch = 5'h00;
    settle;
    chk("standby enable high", 16'h0, {15'h0, standby_q});
  endtask

  // Logic supply drop in mid-run: bank and diagnosis back to default, first answer flagged
  task automatic por_drop;
    int n;
    frame(1'b1, SLH_ADDR_OUT, 5'h05);
    chk("channels before drop", 16'h5, {11'h0, ch_on_q});
    vdd_ok = 1'b0;
    settle;
    chk("channels in power-on reset", 16'h0, {11'h0, ch_on_q});
    chk("ready in power-on reset", 16'h0, {15'h0, spi_ready_q});
    vdd_ok = 1'b1;
    n = 0;
    while (spi_ready_q !== 1'b1 && n < WAKE + 20) begin
      @(negedge mclk);
      n++;
    end
    if (n >= WAKE + 20) begin
      error_cnt++;
      complete_run;
    end
    frame(1'b0, SLH_ADDR_DIAG, 5'h00);
    chk("first frame after supply drop", 16'h8000, rsp);
    frame(1'b0, SLH_ADDR_DIAG, 5'h00);
    chk("diag after supply drop", 16'h0000, rsp);
    chk("idle after supply drop", 16'h1, {15'h0, idle_q});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    power_up;
    write_and_reset;
    limp_home;
    standby_check;
    por_drop;
    complete_run;
  end
endmodule

// file: verilog/slh_pkg.sv
// Constants shared by the supply, reset and limp-home control block
package slh_pkg;
  // ****************************************
  // Serial frame layout
  // ****************************************
  localparam int SLH_FRAME_W = 16;
  localparam int SLH_FR_WR_BIT = 15;
  localparam int SLH_FR_ADDR_HI = 14;
  localparam int SLH_FR_ADDR_LO = 12;
  localparam int SLH_RESP_TER_BIT = 15;
  localparam int SLH_DATA_W = 8;

  // ****************************************
  // Register addresses inside a frame
  // ****************************************
  localparam logic [2:0] SLH_ADDR_OUT = 3'h0;
  localparam logic [2:0] SLH_ADDR_HARDWARE_CONFIG_REG = 3'h1;
  localparam logic [2:0] SLH_ADDR_DIAG = 3'h2;
  localparam logic [2:0] SLH_ADDR_STAT = 3'h3;

  // ****************************************
  // Hardware config register fields and reset values
  // ****************************************
  localparam int SLH_HARDWARE_CONFIG_REG_LHO_BIT = 4;
  localparam int SLH_HARDWARE_CONFIG_REG_RST_BIT = 4;
  localparam int SLH_HARDWARE_CONFIG_REG_WDL_BIT = 3;
  localparam int SLH_HARDWARE_CONFIG_REG_SBM_BIT = 2;
  localparam int SLH_HARDWARE_CONFIG_REG_PWM_BIT = 1;
  localparam int SLH_HARDWARE_CONFIG_REG_CTL_BIT = 0;
  localparam logic [4:0] SLH_HARDWARE_CONFIG_REG_WR_MASK = 5'h0b;
  localparam logic [4:0] SLH_HARDWARE_CONFIG_REG_RST_VAL = 5'h00;
  localparam logic [4:0] SLH_OUT_RST_VAL = 5'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SLH_CLK_PERIOD_NS = 10;
  localparam int SLH_POR_WAKE_US = 500;
  // Longest time: rounds down
  localparam int SLH_POR_WAKE_CYC = (SLH_POR_WAKE_US * 1000) / SLH_CLK_PERIOD_NS;
endpackage

// file: verilog/slh_spi_frame.sv
// Serial frame shifter sampled on the system clock, with daisy-chain pass-through
`timescale 1ns/1ps
module slh_spi_frame #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so_q,
  output logic so_oe_n_q,
  // Frame side
  input wire logic [W-1:0] tx_word,
  output logic [W-1:0] rx_word_q,
  output logic frame_done_q,
  output logic frame_bad_q
);
  localparam int CW = $clog2(W);

  if (W < 2) begin : g_bad_width
    $error("slh_spi_frame: W must be at least 2");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic sclk_prev_q;
  logic cs_prev_q;
  logic [W-1:0] shreg_q;
  logic [CW-1:0] cnt_q;
  logic wrapped_q;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  // Two stages before any logic looks at the pins
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 3'h2;
      sync_q <= 3'h2;
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      meta_q <= {sclk, cs_n, si};
      sync_q <= meta_q;
      sclk_prev_q <= sync_q[2];
      cs_prev_q <= sync_q[1];
    end
  end

  assign rise = sync_q[2] & ~sclk_prev_q & ~sync_q[1];
  assign fall = ~sync_q[2] & sclk_prev_q & ~sync_q[1];
  assign start = cs_prev_q & ~sync_q[1];
  assign stop = ~cs_prev_q & sync_q[1];

  // ****************************************
  // Shift register and bit count
  // ****************************************
  // Counting modulo W lets a chained frame of several words still count as whole
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      shreg_q <= '0;
      cnt_q <= '0;
      wrapped_q <= 1'b0;
    end else if (start) begin
      shreg_q <= tx_word;
      cnt_q <= '0;
      wrapped_q <= 1'b0;
    end else if (rise) begin
      shreg_q <= {shreg_q[W-2:0], sync_q[0]}; // R2
      if (cnt_q == CW'(W - 1)) begin
        cnt_q <= '0;
        wrapped_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // Serial out: MSB at select, then next bit after each falling edge
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      so_q <= 1'b0;
      so_oe_n_q <= 1'b1;
    end else begin
      so_oe_n_q <= sync_q[1];
      if (start) begin
        so_q <= tx_word[W-1];
      end else if (fall) begin
        so_q <= shreg_q[W-1];
      end
    end
  end

  // Frame end: whole words only are accepted
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_word_q <= '0;
      frame_done_q <= 1'b0;
      frame_bad_q <= 1'b0;
    end else begin
      frame_done_q <= stop & wrapped_q & (cnt_q == '0);
      frame_bad_q <= stop & ~(wrapped_q & (cnt_q == '0));
      if (stop) begin
        rx_word_q <= shreg_q;
      end
    end
  end
endmodule

// file: verilog/slh_supply_reset_ctrl.sv
// Supply mode, register reset and limp-home control of a smart high-side switch
// Functional notes
// R1: Logic supply power-up returns every serial register to default.
// R2: Serial interface and daisy chain work whenever logic supply is good.
// R3: Resets clear registers only; power stages and watchdog stay untouched.
// R4: First frame after any reset returns output register with error flag.
// R5: Power-on reset held until logic supply passes the power-on threshold.
// R6: Host waits the wake time, at most 500 us, before first access.
// R7: Writing one to config bit 4 triggers a reset like power-on.
// R8: Reset command clears the register bank and all diagnosis registers.
// R9: Host waits transfer delay time after issuing reset command.
// R10: Limp-home mode holds all writable registers in reset.
// R11: Reads still work in limp-home: limp flag, enable state, errors.
// R12: Watchdog active only with limp-home enable high and load supply present.
// R13: Active unserviced watchdog overrun enters limp-home mode.
// R14: Stand-by only with enable low, channels off, thermal latches clear.
// R15: Idle only with logic supply, channels off, registers at default.
// R16: No current-sense diagnosis in limp-home mode.
// R17: Config bit 4 reads limp flag, and as written is reset command.
// R18: Reset command acts after its carrying frame completes.
`timescale 1ns/1ps
module slh_supply_reset_ctrl
  import slh_pkg::*;
#(
  parameter int CH_N = 5,
  parameter int unsigned POR_WAKE_CYC = SLH_POR_WAKE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Supply monitors and pins
  input wire logic vdd_ok,
  input wire logic vbb_ok,
  input wire logic limp_home_enable,
  input wire logic wd_overrun,
  input wire logic [CH_N-1:0] in_pin,
  input wire logic [CH_N-1:0] thermal_latch,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so_q,
  output logic so_oe_n_q,
  // Status and control towards the power stage
  output logic [CH_N-1:0] ch_on_q,
  output logic wd_active_q,
  output logic limp_home_active_flag_q,
  output logic standby_q,
  output logic idle_q,
  output logic sense_avail_q,
  output logic spi_ready_q
);
  localparam int SW = 4 + 2 * CH_N;
  localparam int WK_W = $clog2(POR_WAKE_CYC + 1);

  if (CH_N < 1 || CH_N > 5) begin : g_bad_ch
    $error("slh_supply_reset_ctrl: CH_N must be 1..5");
  end
  if (POR_WAKE_CYC < 1) begin : g_bad_wake
    $error("slh_supply_reset_ctrl: POR_WAKE_CYC must be at least 1");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;
  logic vdd_s;
  logic vbb_s;
  logic limp_home_enable_s;
  logic wd_ovr_s;
  logic [CH_N-1:0] in_s;
  logic [CH_N-1:0] th_s;

  // Two stages; only the second stage feeds logic
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {vdd_ok, vbb_ok, limp_home_enable, wd_overrun, in_pin, thermal_latch};
      sync_q <= meta_q;
    end
  end

  assign {vdd_s, vbb_s, limp_home_enable_s, wd_ovr_s, in_s, th_s} = sync_q;

  // ****************************************
  // Power-on reset and wake time
  // ****************************************
  logic [WK_W-1:0] wake_cnt_q;

  // Logic supply below threshold keeps the register bank and serial ready in reset and restarts the wake count
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wake_cnt_q <= '0;
      spi_ready_q <= 1'b0;
    end else if (!vdd_s) begin
      wake_cnt_q <= '0; // R5
      spi_ready_q <= 1'b0;
    end else if (wake_cnt_q != WK_W'(POR_WAKE_CYC)) begin
      wake_cnt_q <= wake_cnt_q + 1'b1;
      spi_ready_q <= 1'b0;
    end else begin
      spi_ready_q <= 1'b1;
    end
  end

  // ****************************************
  // Watchdog gating and limp-home
  // ****************************************
  logic limp_q;

  // Only nrst touches this state: register resets must leave the watchdog alone
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wd_active_q <= 1'b0;
      limp_q <= 1'b0;
    end else begin
      wd_active_q <= limp_home_enable_s & vbb_s; // R12
      if (!wd_active_q) begin
        limp_q <= 1'b0; // R3
      end else if (wd_ovr_s) begin
        limp_q <= 1'b1; // R13
      end
    end
  end

  assign limp_home_active_flag_q = limp_q;

  // ****************************************
  // Serial frame decode
  // ****************************************
  logic [SLH_FRAME_W-1:0] tx_word;
  logic [SLH_FRAME_W-1:0] rx_word;
  logic frame_done;
  logic frame_bad;
  logic frame_ok;
  logic fr_wr;
  logic [2:0] fr_addr;
  logic [4:0] fr_data;
  logic soft_rst_q;
  logic bank_clr;
  logic limp_prev_q;
  logic rst_evt;

  slh_spi_frame #(
    .W(SLH_FRAME_W)
  ) u_frame (
    .mclk(mclk),
    .nrst(nrst),
    .sclk(sclk),
    .cs_n(cs_n),
    .si(si),
    .so_q(so_q),
    .so_oe_n_q(so_oe_n_q),
    .tx_word(tx_word),
    .rx_word_q(rx_word),
    .frame_done_q(frame_done),
    .frame_bad_q(frame_bad)
  );

  // Frames before the wake time has run out are dropped
  assign frame_ok = frame_done & spi_ready_q;
  assign fr_wr = rx_word[SLH_FR_WR_BIT];
  assign fr_addr = rx_word[SLH_FR_ADDR_HI:SLH_FR_ADDR_LO];
  assign fr_data = rx_word[4:0];

  // Reset command fires the cycle after its frame has ended
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= frame_ok & fr_wr & (fr_addr == SLH_ADDR_HARDWARE_CONFIG_REG) & fr_data[SLH_HARDWARE_CONFIG_REG_RST_BIT]; // R7 R18 R17
    end
  end

  // Every reset source clears the bank the same way
  assign bank_clr = ~vdd_s | soft_rst_q | limp_q; // R1 R7 R10

  // Limp-home holds the bank for long; only its entry is a reset event, so reads keep working
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      limp_prev_q <= 1'b0;
    end else begin
      limp_prev_q <= limp_q;
    end
  end

  assign rst_evt = ~vdd_s | soft_rst_q | (limp_q & ~limp_prev_q); // R4 R11

  // ****************************************
  // Register bank
  // ****************************************
  logic [4:0] out_q;
  logic [4:0] hardware_config_reg_q;
  logic [CH_N-1:0] diag_q;
  logic ter_q;
  logic [2:0] resp_sel_q;
  logic [SLH_DATA_W-1:0] rd_data;
  logic regs_default;

  // Writable registers; writes are refused while a reset source is active
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      out_q <= SLH_OUT_RST_VAL;
      hardware_config_reg_q <= SLH_HARDWARE_CONFIG_REG_RST_VAL;
    end else if (bank_clr) begin
      out_q <= SLH_OUT_RST_VAL; // R8 R10
      hardware_config_reg_q <= SLH_HARDWARE_CONFIG_REG_RST_VAL;
    end else if (frame_ok && fr_wr) begin
      if (fr_addr == SLH_ADDR_OUT) begin
        out_q <= fr_data;
      end
      if (fr_addr == SLH_ADDR_HARDWARE_CONFIG_REG) begin
        hardware_config_reg_q <= fr_data & SLH_HARDWARE_CONFIG_REG_WR_MASK;
      end
    end
  end

  // Thermal diagnosis is sticky; a latch still high after a clear sets it again
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      diag_q <= '0;
    end else begin
      diag_q <= (bank_clr ? '0 : diag_q) | th_s; // R8
    end
  end

  // Any reset raises the error flag and points the next answer at the output register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ter_q <= 1'b1;
      resp_sel_q <= SLH_ADDR_OUT;
    end else begin
      if (rst_evt || frame_bad) begin
        ter_q <= 1'b1; // R4
      end else if (frame_done) begin
        ter_q <= 1'b0;
      end
      if (rst_evt) begin
        resp_sel_q <= SLH_ADDR_OUT; // R4
      end else if (frame_ok) begin
        resp_sel_q <= fr_addr;
      end
    end
  end

  // Read mux; limp flag and enable state stay visible in limp-home
  always_comb begin
    rd_data = '0;
    case (resp_sel_q)
      SLH_ADDR_OUT: rd_data[4:0] = out_q;
      SLH_ADDR_HARDWARE_CONFIG_REG: begin
        rd_data[4:0] = hardware_config_reg_q;
        rd_data[SLH_HARDWARE_CONFIG_REG_LHO_BIT] = limp_q; // R17 R11
        rd_data[SLH_HARDWARE_CONFIG_REG_SBM_BIT] = standby_q;
      end
      SLH_ADDR_DIAG: rd_data[CH_N-1:0] = diag_q;
      SLH_ADDR_STAT: rd_data[3:0] = {vbb_s, wd_active_q, limp_home_enable_s, limp_q}; // R11
      default: rd_data = '0;
    endcase
  end

  assign tx_word = {ter_q, {(SLH_FRAME_W - 1 - SLH_DATA_W){1'b0}}, rd_data};
  assign regs_default = (out_q == SLH_OUT_RST_VAL) && (hardware_config_reg_q == SLH_HARDWARE_CONFIG_REG_RST_VAL) && (diag_q == '0);

  // ****************************************
  // Channel requests and supply modes
  // ****************************************
  logic [CH_N-1:0] ch_req;

  // Gated mode needs both register bit and pin; otherwise either switches on
  assign ch_req = hardware_config_reg_q[SLH_HARDWARE_CONFIG_REG_PWM_BIT] ? (out_q[CH_N-1:0] & in_s) : (out_q[CH_N-1:0] | in_s);

  // Mode indicators; registered so the outputs come straight from flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ch_on_q <= '0;
      standby_q <= 1'b0;
      idle_q <= 1'b0;
      sense_avail_q <= 1'b0;
    end else begin
      ch_on_q <= ch_req;
      standby_q <= ~limp_home_enable_s & (ch_on_q == '0) & (th_s == '0); // R14
      idle_q <= vdd_s & (ch_on_q == '0) & regs_default; // R15
      sense_avail_q <= vdd_s & vbb_s & ~limp_q; // R16
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_soft_rst;
    frame_ok && fr_wr && fr_addr == SLH_ADDR_HARDWARE_CONFIG_REG && fr_data[SLH_HARDWARE_CONFIG_REG_RST_BIT]
      |=> soft_rst_q ##1 (out_q == SLH_OUT_RST_VAL && hardware_config_reg_q == SLH_HARDWARE_CONFIG_REG_RST_VAL);
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("reset command did not clear bank"); // R7

  property p_first_frame;
    soft_rst_q |=> ter_q && resp_sel_q == SLH_ADDR_OUT && tx_word[SLH_RESP_TER_BIT];
  endproperty
  a_first_frame: assert property (p_first_frame) else $error("no error flag after reset"); // R4

  property p_limp_hold;
    limp_q |=> out_q == SLH_OUT_RST_VAL && hardware_config_reg_q == SLH_HARDWARE_CONFIG_REG_RST_VAL;
  endproperty
  a_limp_hold: assert property (p_limp_hold) else $error("registers not held in limp-home"); // R10

  property p_limp_enter;
    wd_active_q && wd_ovr_s |=> limp_q;
  endproperty
  a_limp_enter: assert property (p_limp_enter) else $error("overrun did not enter limp-home"); // R13

  property p_wd_gate;
    !limp_home_enable_s |=> !wd_active_q ##1 !limp_q;
  endproperty
  a_wd_gate: assert property (p_wd_gate) else $error("watchdog active without enable"); // R12

  property p_limp_survives;
    soft_rst_q && limp_q && wd_active_q && limp_home_enable_s && vbb_s |=> limp_q;
  endproperty
  a_limp_survives: assert property (p_limp_survives) else $error("reset disturbed limp-home"); // R3

  property p_por;
    !vdd_s |=> out_q == SLH_OUT_RST_VAL && !spi_ready_q ##1 !spi_ready_q;
  endproperty
  a_por: assert property (p_por) else $error("power-on reset not held"); // R1

  property p_standby;
    standby_q |-> $past(!limp_home_enable_s && ch_on_q == '0 && th_s == '0);
  endproperty
  a_standby: assert property (p_standby) else $error("stand-by without its conditions"); // R14

  property p_idle;
    idle_q |-> $past(vdd_s && ch_on_q == '0 && regs_default);
  endproperty
  a_idle: assert property (p_idle) else $error("idle without its conditions"); // R15

  property p_sense;
    limp_q |=> !sense_avail_q;
  endproperty
  a_sense: assert property (p_sense) else $error("current sense offered in limp-home"); // R16

  c_soft_rst: cover property (soft_rst_q ##[1:200] frame_done);
  c_limp: cover property ($rose(limp_q));
  c_standby: cover property ($rose(standby_q));
  c_idle: cover property (soft_rst_q ##[1:20] idle_q);
endmodule
